// ---- rtl/pcic_cfg.svh ----
// constants for the configuration identity and command block
`ifndef PCIC_CFG_SVH
`define PCIC_CFG_SVH

// ****************************************************************
// byte offsets and dword indices of the configuration header
// ****************************************************************
`define PCIC_OFS_MAKER 8'h00
`define PCIC_OFS_PART 8'h02
`define PCIC_OFS_CMD 8'h04
`define PCIC_DW_IDENT 6'h00
`define PCIC_DW_CMD 6'h01

// ****************************************************************
// command register field positions
// ****************************************************************
`define PCIC_BIT_INT_INHIBIT 10
`define PCIC_BIT_BACK_TO_BACK 9
`define PCIC_BIT_SYS_ERR 8
`define PCIC_BIT_RSVD7 7
`define PCIC_BIT_PARITY 6
`define PCIC_BIT_PALETTE 5
`define PCIC_BIT_INVALIDATE 4
`define PCIC_BIT_SPECIAL 3
`define PCIC_BIT_INITIATOR 2
`define PCIC_BIT_MEM_SPACE 1
`define PCIC_BIT_PORT_SPACE 0

// ****************************************************************
// reset values, masks and identity defaults
// ****************************************************************
`define PCIC_CMD_RESET 16'h0000
`define PCIC_CMD_WR_MASK 16'h0556
`define PCIC_RSP_RESET 32'h00000000
`define PCIC_MAKER_DEFAULT 16'h1A2B
`define PCIC_PART_DEFAULT 16'h3C4D

// ****************************************************************
// initiator bus command codes
// ****************************************************************
`define PCIC_BUSCMD_MEMWR 4'h7
`define PCIC_BUSCMD_MWI 4'hF
`define PCIC_BUSCMD_IDLE 4'h0

`endif

// ---- rtl/pcic_pkg.sv ----
// types shared by the configuration identity and command block
package pcic_pkg;

   // ****************************************************************
   // configuration access request and answer
   // ****************************************************************
   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] dword;
      logic [3:0] byteEn;
      logic [31:0] wrData;
   } pcic_cfg_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] rdData;
   } pcic_cfg_rsp_s;

   // ****************************************************************
   // events and requests from the host-controller datapath
   // ****************************************************************
   typedef struct packed {
      logic intPending;
      logic addrParityErr;
      logic dataParityErr;
      logic masterReq;
      logic memWriteReq;
      logic memCycleHit;
      logic specialCycle;
      logic portCycleHit;
   } pcic_dp_req_s;

   // ****************************************************************
   // gated bus-side results
   // ****************************************************************
   typedef struct packed {
      logic intAssert;
      logic serrOut;
      logic serrOe;
      logic perrOut;
      logic perrOe;
      logic masterGo;
      logic [3:0] busCmd;
      logic memClaim;
      logic specialAccept;
      logic portClaim;
      logic backToBack;
   } pcic_dp_gate_s;

endpackage : pcic_pkg

// ---- rtl/pcic_gate.sv ----
// gating of datapath requests by the command register enables
`timescale 1ns/10ps
`include "pcic_cfg.svh"

module pcic_gate (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // command register contents
   input wire logic [15:0] command,
   // datapath requests
   input wire pcic_pkg::pcic_dp_req_s dpReq,
   // gated bus-side results
   output pcic_pkg::pcic_dp_gate_s dpGate
);

   pcic_pkg::pcic_dp_gate_s next_dpGate;

   // combine each datapath request except specialCycle and portCycleHit with its enable bit; those two are dropped
   always_comb begin
      next_dpGate = '0;
      // pending status is never altered, only its drive is blocked
      next_dpGate.intAssert = dpReq.intPending &
         ~command[`PCIC_BIT_INT_INHIBIT];
      // open-drain error pins pull low while enabled
      next_dpGate.serrOut = 1'b0;
      next_dpGate.serrOe = dpReq.addrParityErr & command[`PCIC_BIT_SYS_ERR];
      next_dpGate.perrOut = 1'b0;
      next_dpGate.perrOe = dpReq.dataParityErr & command[`PCIC_BIT_PARITY];
      next_dpGate.masterGo = dpReq.masterReq & command[`PCIC_BIT_INITIATOR];
      if (dpReq.memWriteReq && command[`PCIC_BIT_INITIATOR]) begin
         if (command[`PCIC_BIT_INVALIDATE]) begin
            next_dpGate.busCmd = `PCIC_BUSCMD_MWI;
         end else begin
            next_dpGate.busCmd = `PCIC_BUSCMD_MEMWR;
         end
      end else begin
         next_dpGate.busCmd = `PCIC_BUSCMD_IDLE;
      end
      next_dpGate.memClaim = dpReq.memCycleHit & command[`PCIC_BIT_MEM_SPACE];
      next_dpGate.specialAccept = 1'b0;
      next_dpGate.portClaim = 1'b0;
      next_dpGate.backToBack = 1'b0;
   end

   // register the gated results
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dpGate <= '0;
      end else begin
         dpGate <= next_dpGate;
      end
   end

endmodule : pcic_gate

// ---- rtl/pcic_top.sv ----
// configuration identity words and command register with enable gating
`timescale 1ns/10ps
`include "pcic_cfg.svh"


module pcic_top #(
   parameter logic [15:0] MAKER_ID = `PCIC_MAKER_DEFAULT, // arbitrary value
   parameter logic [15:0] PART_ID = `PCIC_PART_DEFAULT // arbitrary value
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // configuration access port
   input wire pcic_pkg::pcic_cfg_req_s cfgReq,
   output pcic_pkg::pcic_cfg_rsp_s cfgRsp,
   // datapath requests
   input wire pcic_pkg::pcic_dp_req_s dpReq,
   // command register contents and gated results
   output logic [15:0] command,
   output pcic_pkg::pcic_dp_gate_s dpGate
);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // expand byte enables of the low half-word into a bit mask
   function automatic logic [15:0] laneMask(input logic [3:0] byteEn);
      laneMask = {{8{byteEn[1]}}, {8{byteEn[0]}}};
   endfunction : laneMask

   // merge a write into the command register, writable bits only
   function automatic logic [15:0] cmdMerge(
      input logic [15:0] current,
      input logic [15:0] data,
      input logic [3:0] byteEn
   );
      logic [15:0] mask;
      mask = laneMask(byteEn) & `PCIC_CMD_WR_MASK;
      cmdMerge = (current & ~mask) | (data & mask);
   endfunction : cmdMerge

   // read view of the command register with hardwired bits zero
   function automatic logic [15:0] cmdView(input logic [15:0] current);
      cmdView = current & `PCIC_CMD_WR_MASK;
   endfunction : cmdView

   // read data for a dword index; unmapped dwords return zero
   function automatic logic [31:0] readWord(
      input logic [5:0] dword,
      input logic [15:0] current
   );
      case (dword)
         `PCIC_DW_IDENT: begin
            readWord = {PART_ID, MAKER_ID};
         end
         `PCIC_DW_CMD: begin
            // status half reads zero here, it lives elsewhere
            readWord = {16'h0000, cmdView(current)};
         end
         default: begin
            readWord = 32'h00000000;
         end
      endcase
   endfunction : readWord

   // ****************************************************************
   // command register
   // ****************************************************************

   logic [15:0] next_command;
   logic cmdWrite;

   // a write hits the command register only at its dword
   assign cmdWrite = cfgReq.valid & cfgReq.write & (cfgReq.dword == `PCIC_DW_CMD);

   // identity dword writes fall through and change nothing
   always_comb begin
      next_command = command;
      if (cmdWrite) begin
         next_command = cmdMerge(command, cfgReq.wrData[15:0], cfgReq.byteEn);
      end
   end

   // store the command register, cleared on reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         command <= `PCIC_CMD_RESET;
      end else begin
         command <= next_command;
      end
   end

   // ****************************************************************
   // configuration answer
   // ****************************************************************

   pcic_pkg::pcic_cfg_rsp_s next_cfgRsp;

   // every access is answered one cycle later; reads carry data
   always_comb begin
      next_cfgRsp = '0;
      if (cfgReq.valid) begin
         next_cfgRsp.valid = 1'b1;
         if (!cfgReq.write) begin
            next_cfgRsp.rdData = readWord(cfgReq.dword, command);
         end
      end
   end

   // register the answer
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cfgRsp <= '0;
      end else begin
         cfgRsp <= next_cfgRsp;
      end
   end

   // ****************************************************************
   // enable gating of the datapath
   // ****************************************************************

   // software must set memory response before touching mapped registers
   pcic_gate u_gate (
      .clock(clock),
      .arst_n(arst_n),
      .command(command),
      .dpReq(dpReq),
      .dpGate(dpGate)
   );

endmodule : pcic_top

// ---- testbench/pcic_props.sv ----
// checker for the configuration identity and command block
`timescale 1ns/10ps
`include "pcic_cfg.svh"

module pcic_props #(
   parameter logic [15:0] MAKER_ID = 16'h0000,
   parameter logic [15:0] PART_ID = 16'h0000
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // access port
   input wire pcic_pkg::pcic_cfg_req_s cfgReq,
   input wire pcic_pkg::pcic_cfg_rsp_s cfgRsp,
   // datapath side
   input wire pcic_pkg::pcic_dp_req_s dpReq,
   input wire logic [15:0] command,
   input wire pcic_pkg::pcic_dp_gate_s dpGate
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // identity read and low-byte command write
   sequence idRead;
      cfgReq.valid && !cfgReq.write && cfgReq.dword == `PCIC_DW_IDENT;
   endsequence
   sequence lowWrite;
      cfgReq.valid && cfgReq.write && cfgReq.dword == `PCIC_DW_CMD && cfgReq.byteEn[0];
   endsequence
   ident_read_a: assert property (idRead |=> cfgRsp.rdData == {PART_ID, MAKER_ID})
      else $error("identity word wrong");
   fixed_zero_a: assert property ((command & ~`PCIC_CMD_WR_MASK) == 16'h0000)
      else $error("fixed command bit set");
   low_write_a: assert property (lowWrite |=>
      command[7:0] == ($past(cfgReq.wrData[7:0]) & 8'h56))
      else $error("low command byte wrong");
   int_gate_a: assert property (1'b1 |=>
      dpGate.intAssert == $past(dpReq.intPending && !command[10]))
      else $error("interrupt gating wrong");
   serr_gate_a: assert property (1'b1 |=>
      dpGate.serrOe == $past(dpReq.addrParityErr && command[8]))
      else $error("system error gating wrong");
   perr_gate_a: assert property (1'b1 |=>
      dpGate.perrOe == $past(dpReq.dataParityErr && command[6]))
      else $error("parity gating wrong");
   master_gate_a: assert property (1'b1 |=>
      dpGate.masterGo == $past(dpReq.masterReq && command[2]))
      else $error("initiator gating wrong");
   mem_claim_a: assert property (1'b1 |=>
      dpGate.memClaim == $past(dpReq.memCycleHit && command[1]))
      else $error("memory claim wrong");
   write_cmd_a: assert property (dpReq.memWriteReq && command[2] |=>
      dpGate.busCmd == ($past(command[4]) ? `PCIC_BUSCMD_MWI : `PCIC_BUSCMD_MEMWR))
      else $error("write command code wrong");
   unsupported_a: assert property (
      !(dpGate.specialAccept || dpGate.portClaim || dpGate.backToBack))
      else $error("unsupported feature active");
endmodule : pcic_props

bind pcic_top pcic_props #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) pcic_props_i (.clock(clock),
   .arst_n(arst_n), .cfgReq(cfgReq), .cfgRsp(cfgRsp), .dpReq(dpReq), .command(command),
   .dpGate(dpGate));

// ---- testbench/pcic_host.sv ----
// configuration host model issuing single accesses
`timescale 1ns/10ps

module pcic_host (
   // clock
   input wire logic clock,
   // access port
   output pcic_pkg::pcic_cfg_req_s cfgReq,
   input wire pcic_pkg::pcic_cfg_rsp_s cfgRsp
);
   // idle port until the first access
   initial begin
      cfgReq = '0;
   end
   // one request pulse; released fields show inverted junk, answer taken after the take edge
   task automatic xfer(input logic w, input logic [5:0] dw, input logic [3:0] be,
      input logic [31:0] d, output logic [32:0] r);
      @(posedge clock);
      cfgReq <= '{valid: 1'b1, write: w, dword: dw, byteEn: be, wrData: d};
      @(posedge clock);
      cfgReq <= '{valid: 1'b0, write: ~w, dword: ~dw, byteEn: ~be, wrData: ~d};
      #1;
      r = {cfgRsp.valid, cfgRsp.rdData};
   endtask : xfer
endmodule : pcic_host

// ---- testbench/pcic_top_tb.sv ----
// self-checking bench for the configuration identity and command block
`timescale 1ns/10ps
`include "pcic_cfg.svh"
`define CHK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("BAD %s expected %h seen %h", nm, e, g); \
   end \
end

module pcic_top_tb;
   localparam logic [15:0] MAKER = 16'h5A61; // arbitrary value
   localparam logic [15:0] PART = 16'h7E32; // arbitrary value
   localparam logic [15:0] CMDS [5] = '{16'h0500, 16'h0016, 16'h0006, 16'h0040, 16'h0010};
   logic clock;
   logic arst_n;
   pcic_pkg::pcic_cfg_req_s cfgReq;
   pcic_pkg::pcic_cfg_rsp_s cfgRsp;
   pcic_pkg::pcic_dp_req_s dpReq;
   logic [15:0] command;
   pcic_pkg::pcic_dp_gate_s dpGate;
   int fails = 0;
   int check_count = 0;
   logic [32:0] rsp;

   pcic_top #(.MAKER_ID(MAKER), .PART_ID(PART)) pcic_top_i (.clock(clock), .arst_n(arst_n),
      .cfgReq(cfgReq), .cfgRsp(cfgRsp), .dpReq(dpReq), .command(command), .dpGate(dpGate));
   pcic_host pcic_host_i (.clock(clock), .cfgReq(cfgReq), .cfgRsp(cfgRsp));

   // free-running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // write and read with answer checks
   task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
      pcic_host_i.xfer(1'b1, dw, be, d, rsp);
      `CHK("writeAnswer", 33'h100000000, rsp)
   endtask : wr
   task automatic rd(input logic [5:0] dw, input logic [31:0] e);
      pcic_host_i.xfer(1'b0, dw, 4'hF, 32'h00000000, rsp);
      `CHK("readAnswer", {1'b1, e}, rsp)
   endtask : rd
   // apply datapath levels and compare the gated results
   task automatic gate(input pcic_pkg::pcic_dp_req_s q, input logic [15:0] c);
      pcic_pkg::pcic_dp_gate_s e;
      e = '0;
      e.intAssert = q.intPending & ~c[10];
      e.serrOe = q.addrParityErr & c[8];
      e.perrOe = q.dataParityErr & c[6];
      e.masterGo = q.masterReq & c[2];
      if (q.memWriteReq & c[2]) begin
         e.busCmd = c[4] ? `PCIC_BUSCMD_MWI : `PCIC_BUSCMD_MEMWR;
      end else begin
         e.busCmd = `PCIC_BUSCMD_IDLE;
      end
      e.memClaim = q.memCycleHit & c[1];
      @(posedge clock);
      dpReq <= q;
      repeat (2) @(posedge clock);
      #1;
      `CHK("dpGate", e, dpGate)
   endtask : gate
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask : done
   // counts and verdict
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge clock);
      fails++;
      complete_run();
   end
   // main sequence
   initial begin
      arst_n = 1'b0;
      dpReq = '0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      rd(6'h01, 32'h00000000);
      rd(6'h00, {PART, MAKER});
      wr(6'h00, 4'hF, 32'hFFFFFFFF);
      rd(6'h00, {PART, MAKER});
      done("identity");
      wr(6'h01, 4'h3, 32'hFFFFFFFF);
      rd(6'h01, 32'h00000556);
      `CHK("fixedBits", 16'h0000, command & ~`PCIC_CMD_WR_MASK)
      wr(6'h01, 4'h1, 32'h00000000);
      rd(6'h01, 32'h00000500);
      wr(6'h3F, 4'h3, 32'h00000000);
      rd(6'h3F, 32'h00000000);
      rd(6'h01, 32'h00000500);
      done("command");
      foreach (CMDS[i]) begin
         wr(6'h01, 4'h3, {16'h0000, CMDS[i]});
         gate(8'hFF, CMDS[i]);
         gate(8'h00, CMDS[i]);
      end
      done("gating");
      @(posedge clock);
      arst_n <= 1'b0;
      #1;
      `CHK("resetCmd", 16'h0000, command)
      @(posedge clock);
      arst_n <= 1'b1;
      rd(6'h01, 32'h00000000);
      done("reset");
      complete_run();
   end
endmodule : pcic_top_tb
